// ==== core/trig_pkg.sv ====
package trig_pkg;
	// ----------------------------------------
	// Timing
	// ----------------------------------------
	localparam int CLOCK_HZ         = 10_000_000;
	localparam int TIME_STEP_HZ     = 100;
	localparam int TICK_CYCLES      = CLOCK_HZ / TIME_STEP_HZ;
	localparam int NOMINAL_HZ       = 60;
	localparam int REFRESH_PERIODS  = 2;
	localparam int REFRESH_CYCLES   = CLOCK_HZ * REFRESH_PERIODS / NOMINAL_HZ;

	// ----------------------------------------
	// Sizes and indexes
	// ----------------------------------------
	localparam int VW        = 16;
	localparam int NUM_DET   = 4;
	localparam int NUM_TH    = 8;
	localparam int NUM_CMP   = 23;
	localparam int DET_FREQ  = 0;
	localparam int DET_VOLT  = 1;
	localparam int DET_CURR  = 2;
	localparam int DET_POWER = 3;
	localparam int TH_FREQ_LOW  = 0;
	localparam int TH_FREQ_HIGH = 1;
	localparam int TH_VOLT_LOW  = 2;
	localparam int TH_VOLT_HIGH = 3;
	localparam int TH_CURR      = 4;
	localparam int TH_POWER     = 5;
	localparam int CMP_VOLT_LOW  = 2;
	localparam int CMP_VOLT_HIGH = 5;
	localparam int CMP_CURR      = 8;
	localparam int CMP_POWER     = 11;
	localparam logic [NUM_CMP-1:0] CMP_OVER = 23'h7fffe2;

	// ----------------------------------------
	// Register map and fields
	// ----------------------------------------
	localparam logic [7:0] ADDR_CONTROL = 8'h00;
	localparam logic [7:0] ADDR_STATUS  = 8'h04;
	localparam logic [7:0] ADDR_THRESH  = 8'h08;
	localparam logic [7:0] ADDR_PICKUP  = 8'h28;
	localparam logic [7:0] ADDR_DROPOUT = 8'h38;
	localparam int CTRL_ENABLE = 0;
	localparam int CTRL_EVENTS = 4;
	localparam logic [7:0] CONTROL_RESET = 8'h00;

	// ----------------------------------------
	// Settings: units 0.01 Hz, 0.001 pu, 0.01 s
	// ----------------------------------------
	localparam logic [VW-1:0] TH_RESET [NUM_TH] = '{16'h1324, 16'h17d4, 16'h0320, 16'h04b0,
		16'h0708, 16'h04e2, 16'h04e2, 16'h04e2};
	localparam logic [VW-1:0] TH_MIN [NUM_TH] = '{16'h07d0, 16'h07d0, 16'h00fa, 16'h02ee,
		16'h0064, 16'h00fa, 16'h00fa, 16'h00fa};
	localparam logic [VW-1:0] TH_MAX [NUM_TH] = '{16'h1b58, 16'h1b58, 16'h04e2, 16'h06d6,
		16'h7530, 16'h0bb8, 16'h0bb8, 16'h0bb8};
	localparam logic [VW-1:0] PICKUP_RESET  = 16'h000a;
	localparam logic [VW-1:0] DROPOUT_RESET = 16'h0064;
	localparam logic [VW-1:0] TIME_MAX      = 16'hea60;
	localparam logic [VW-1:0] FREQ_HYST     = 16'h0003;
	localparam logic [VW-1:0] DEAD_VOLT     = 16'h0064;
	localparam int PCT_HYST = 3;
	localparam int PCT_FULL = 100;

	function automatic logic [VW-1:0] pct_band(input logic [VW-1:0] level);
		return VW'((32'(level) * PCT_HYST) / PCT_FULL);
	endfunction

	function automatic logic [VW-1:0] clamp(input logic [VW-1:0] v, lo, hi);
		return (v < lo) ? lo : ((v > hi) ? hi : v);
	endfunction
endpackage

// ==== core/hyst_cmp.sv ====
`timescale 1ns/1ns
module hyst_cmp #(
	parameter bit OVER = 1'b1
) (
	input  wire logic        clock,
	input  wire logic        rst,
	input  wire logic        refresh,
	input  wire logic        clear,
	input  wire logic [15:0] value,
	input  wire logic [15:0] level,
	input  wire logic [15:0] rel_lvl,
	output logic             state
);
	// Set beyond level, reset only back past rel_lvl
	always_ff @(posedge clock) begin
		if (rst || clear) begin
			state <= 1'b0;
		end else if (refresh) begin
			if (OVER) begin
				state <= state ? (value >= rel_lvl) : (value > level);
			end else begin
				state <= state ? (value <= rel_lvl) : (value < level);
			end
		end
	end

	chk_hold_between: assert property (
		@(posedge clock) disable iff (rst) (!refresh && !clear) |=> $stable(state))
		else $error("comparator moved outside a refresh");

	chk_band_holds: assert property (
		@(posedge clock) disable iff (rst)
		(refresh && !clear && state && OVER && value >= rel_lvl) |=> state)
		else $error("comparator released inside its band");
endmodule

// ==== core/det_timer.sv ====
`timescale 1ns/1ns
module det_timer (
	input  wire logic        clock,
	input  wire logic        rst,
	input  wire logic        tick,
	input  wire logic        clear,
	input  wire logic        cond,
	input  wire logic [15:0] pickup_time,
	input  wire logic [15:0] dropout_time,
	output logic             active
);
	logic [15:0] count;

	// Counts 10 ms ticks; a delay may run up to one tick short
	always_ff @(posedge clock) begin
		if (rst || clear) begin
			active <= 1'b0;
			count  <= 16'h0000;
		end else if (active == cond) begin
			count <= 16'h0000;
		end else if (count >= (active ? dropout_time : pickup_time)) begin
			active <= cond;
			count  <= 16'h0000;
		end else if (tick) begin
			count <= count + 16'h0001;
		end
	end

	chk_no_spurious: assert property (
		@(posedge clock) disable iff (rst) (!clear && !active && !cond) |=> !active)
		else $error("output asserted with no condition");

	chk_dropout_hold: assert property (
		@(posedge clock) disable iff (rst)
		(!clear && active && !cond && count == 16'h0000 && dropout_time != 16'h0000) |=> active)
		else $error("output dropped before dropout delay");
endmodule

// ==== core/trig_top.sv ====
// Decided for this implementation: the Avalon-MM register port and the address map.
`timescale 1ns/1ns
// How it works
// - Four detectors each have an enable, off after reset; disabled never triggers.
// - Frequency trips below low threshold, 20.00-70.00 Hz, default 49.00, 0.03 Hz band.
// - Frequency trips above high threshold, same range, default 61.00, 0.03 Hz band.
// - Condition must persist for pickup delay, 0-600.00 s, default 0.10 s.
// - Output holds for dropout delay after clearing, 0-600.00 s, default 1.00 s.
// - Each detector has a block input; while high the detector is inhibited.
// - Events enable, off by default, logs each detector's pickup and dropout.
// - Voltage uses separate low and high thresholds on one common output.
// - Each voltage and current channel is judged alone; any one may trigger.
// - Voltage channels below 0.1 pu never pick up.
// - Low voltage threshold 0.250-1.250 pu, default 0.800, 3% band.
// - High voltage threshold 0.750-1.750 pu, default 1.200, 3% band.
// - Current trips above pickup, 0.100-30.000 pu, default 1.800, 3% band.
// - Active, reactive, apparent thresholds feed one power output.
// - Power checks both per-phase and three-phase quantities.
// - Power thresholds 0.250-3.000 pu, default 1.250, 3% band each.
// - Three-phase power compares against three times the threshold.
// - All detector outputs are ORed into one recorder trigger.
// - Trigger logic is re-evaluated once every two power cycles.
// - Frequency detector drops out when frequency is not measurable.
module trig_top #(
	parameter int TICK_CYCLES    = trig_pkg::TICK_CYCLES,
	parameter int REFRESH_CYCLES = trig_pkg::REFRESH_CYCLES
) (
	input  wire logic                  clock,
	input  wire logic                  rst,
	input  wire logic [7:0]            avs_address,
	input  wire logic                  avs_read,
	input  wire logic                  avs_write,
	input  wire logic [31:0]           avs_writedata,
	output logic      [31:0]           avs_readdata,
	output logic                       avs_waitrequest,
	input  wire logic [15:0]           frequency,
	input  wire logic                  freq_valid,
	input  wire logic [2:0][15:0]      phase_volt,
	input  wire logic [2:0][15:0]      phase_curr,
	input  wire logic [2:0][2:0][15:0] phase_power,
	input  wire logic [2:0][15:0]      total_power,
	input  wire logic [3:0]            block,
	output logic      [3:0]            trigger,
	output logic                       recorder_trigger,
	output logic      [3:0]            event_pickup,
	output logic      [3:0]            event_dropout
);
	// ----------------------------------------
	// Declarations
	// ----------------------------------------
	logic [7:0]  control;
	logic [15:0] thr          [trig_pkg::NUM_TH];
	logic [15:0] pickup_time  [trig_pkg::NUM_DET];
	logic [15:0] dropout_time [trig_pkg::NUM_DET];
	logic [15:0] cmp_value    [trig_pkg::NUM_CMP];
	logic [15:0] cmp_level    [trig_pkg::NUM_CMP];
	logic [15:0] cmp_rel      [trig_pkg::NUM_CMP];
	logic [trig_pkg::NUM_CMP-1:0] cmp_state;
	logic [19:0] tick_cnt;
	logic [19:0] refresh_cnt;
	logic        tick;
	logic        refresh;
	logic [2:0]  volt_live;
	logic [3:0]  enable;
	logic [3:0]  events;
	logic [3:0]  cond;
	logic [3:0]  clear;
	logic [3:0]  active;
	logic [31:0] next_readdata;
	logic        wr_hit;

	assign enable = control[trig_pkg::CTRL_ENABLE +: 4];
	assign events = control[trig_pkg::CTRL_EVENTS +: 4];
	assign wr_hit = avs_write && !avs_waitrequest;

	// ----------------------------------------
	// Time base
	// ----------------------------------------
	always_ff @(posedge clock) begin
		if (rst || tick_cnt == 20'(TICK_CYCLES - 1)) begin
			tick_cnt <= 20'h00000;
		end else begin
			tick_cnt <= tick_cnt + 20'h00001;
		end
	end

	always_ff @(posedge clock) begin
		tick <= !rst && tick_cnt == 20'(TICK_CYCLES - 1);
	end

	// Slow refresh trades response time for settled phasor values
	always_ff @(posedge clock) begin
		if (rst || refresh_cnt == 20'(REFRESH_CYCLES - 1)) begin
			refresh_cnt <= 20'h00000;
		end else begin
			refresh_cnt <= refresh_cnt + 20'h00001;
		end
	end

	always_ff @(posedge clock) begin
		refresh <= !rst && refresh_cnt == 20'(REFRESH_CYCLES - 1);
	end

	// ----------------------------------------
	// Register bus
	// ----------------------------------------
	always_ff @(posedge clock) begin
		if (rst) begin
			avs_waitrequest <= 1'b1;
			avs_readdata    <= 32'h00000000;
		end else if ((avs_read || avs_write) && avs_waitrequest) begin
			avs_waitrequest <= 1'b0;
			avs_readdata    <= avs_read ? next_readdata : 32'h00000000;
		end else begin
			avs_waitrequest <= 1'b1;
		end
	end

	always_comb begin
		next_readdata = 32'h00000000;
		if (avs_address == trig_pkg::ADDR_CONTROL) begin
			next_readdata = {24'h000000, control};
		end
		if (avs_address == trig_pkg::ADDR_STATUS) begin
			next_readdata = {24'h000000, cond, trigger};
		end
		for (int i = 0; i < trig_pkg::NUM_TH; i++) begin
			if (avs_address == trig_pkg::ADDR_THRESH + 8'(4 * i)) begin
				next_readdata = {16'h0000, thr[i]};
			end
		end
		for (int i = 0; i < trig_pkg::NUM_DET; i++) begin
			if (avs_address == trig_pkg::ADDR_PICKUP + 8'(4 * i)) begin
				next_readdata = {16'h0000, pickup_time[i]};
			end
			if (avs_address == trig_pkg::ADDR_DROPOUT + 8'(4 * i)) begin
				next_readdata = {16'h0000, dropout_time[i]};
			end
		end
	end

	// Writes are clamped to the settable range
	always_ff @(posedge clock) begin
		if (rst) begin
			control <= trig_pkg::CONTROL_RESET;
			for (int i = 0; i < trig_pkg::NUM_TH; i++) begin
				thr[i] <= trig_pkg::TH_RESET[i];
			end
			for (int i = 0; i < trig_pkg::NUM_DET; i++) begin
				pickup_time[i]  <= trig_pkg::PICKUP_RESET;
				dropout_time[i] <= trig_pkg::DROPOUT_RESET;
			end
		end else if (wr_hit) begin
			if (avs_address == trig_pkg::ADDR_CONTROL) begin
				control <= avs_writedata[7:0];
			end
			for (int i = 0; i < trig_pkg::NUM_TH; i++) begin
				if (avs_address == trig_pkg::ADDR_THRESH + 8'(4 * i)) begin
					thr[i] <= trig_pkg::clamp(avs_writedata[15:0], trig_pkg::TH_MIN[i],
						trig_pkg::TH_MAX[i]);
				end
			end
			for (int i = 0; i < trig_pkg::NUM_DET; i++) begin
				if (avs_address == trig_pkg::ADDR_PICKUP + 8'(4 * i)) begin
					pickup_time[i] <= trig_pkg::clamp(avs_writedata[15:0], 16'h0000,
						trig_pkg::TIME_MAX);
				end
				if (avs_address == trig_pkg::ADDR_DROPOUT + 8'(4 * i)) begin
					dropout_time[i] <= trig_pkg::clamp(avs_writedata[15:0], 16'h0000,
						trig_pkg::TIME_MAX);
				end
			end
		end
	end

	// ----------------------------------------
	// Comparator inputs
	// ----------------------------------------
	always_comb begin
		cmp_value[0] = frequency;
		cmp_level[0] = thr[trig_pkg::TH_FREQ_LOW];
		cmp_rel[0]   = thr[trig_pkg::TH_FREQ_LOW] + trig_pkg::FREQ_HYST;
		cmp_value[1] = frequency;
		cmp_level[1] = thr[trig_pkg::TH_FREQ_HIGH];
		cmp_rel[1]   = thr[trig_pkg::TH_FREQ_HIGH] - trig_pkg::FREQ_HYST;
		for (int c = 0; c < 3; c++) begin
			cmp_value[trig_pkg::CMP_VOLT_LOW + c]  = phase_volt[c];
			cmp_level[trig_pkg::CMP_VOLT_LOW + c]  = thr[trig_pkg::TH_VOLT_LOW];
			cmp_rel[trig_pkg::CMP_VOLT_LOW + c]    = thr[trig_pkg::TH_VOLT_LOW]
				+ trig_pkg::pct_band(thr[trig_pkg::TH_VOLT_LOW]);
			cmp_value[trig_pkg::CMP_VOLT_HIGH + c] = phase_volt[c];
			cmp_level[trig_pkg::CMP_VOLT_HIGH + c] = thr[trig_pkg::TH_VOLT_HIGH];
			cmp_rel[trig_pkg::CMP_VOLT_HIGH + c]   = thr[trig_pkg::TH_VOLT_HIGH]
				- trig_pkg::pct_band(thr[trig_pkg::TH_VOLT_HIGH]);
			cmp_value[trig_pkg::CMP_CURR + c]      = phase_curr[c];
			cmp_level[trig_pkg::CMP_CURR + c]      = thr[trig_pkg::TH_CURR];
			cmp_rel[trig_pkg::CMP_CURR + c]        = thr[trig_pkg::TH_CURR]
				- trig_pkg::pct_band(thr[trig_pkg::TH_CURR]);
		end
		for (int t = 0; t < 3; t++) begin
			for (int p = 0; p < 4; p++) begin
				// Total power judged against three single-phase bases
				cmp_value[trig_pkg::CMP_POWER + 4 * t + p] = (p == 3) ? total_power[t]
					: phase_power[t][p % 3];
				cmp_level[trig_pkg::CMP_POWER + 4 * t + p] = (p == 3)
					? 16'(thr[trig_pkg::TH_POWER + t] * 3) : thr[trig_pkg::TH_POWER + t];
				cmp_rel[trig_pkg::CMP_POWER + 4 * t + p] =
					cmp_level[trig_pkg::CMP_POWER + 4 * t + p]
					- trig_pkg::pct_band(cmp_level[trig_pkg::CMP_POWER + 4 * t + p]);
			end
		end
	end

	// ----------------------------------------
	// Comparators and detectors
	// ----------------------------------------
	generate
		for (genvar k = 0; k < trig_pkg::NUM_CMP; k++) begin : g_cmp
			hyst_cmp #(
				.OVER (trig_pkg::CMP_OVER[k])
			) u_cmp (
				.clock   (clock),
				.rst     (rst),
				.refresh (refresh),
				.clear   (clear[k < 2 ? 0 : (k < 8 ? 1 : (k < 11 ? 2 : 3))]),
				.value   (cmp_value[k]),
				.level   (cmp_level[k]),
				.rel_lvl (cmp_rel[k]),
				.state   (cmp_state[k])
			);
		end
	endgenerate

	// A dead channel would otherwise look like deep undervoltage
	always_ff @(posedge clock) begin
		if (rst) begin
			volt_live <= 3'h0;
		end else if (refresh) begin
			for (int c = 0; c < 3; c++) begin
				volt_live[c] <= phase_volt[c] >= trig_pkg::DEAD_VOLT;
			end
		end
	end

	always_comb begin
		cond[trig_pkg::DET_FREQ]  = |cmp_state[1:0];
		cond[trig_pkg::DET_VOLT]  = |((cmp_state[4:2] | cmp_state[7:5]) & volt_live);
		cond[trig_pkg::DET_CURR]  = |cmp_state[10:8];
		cond[trig_pkg::DET_POWER] = |cmp_state[22:11];
		clear = ~enable | block;
		clear[trig_pkg::DET_FREQ] = clear[trig_pkg::DET_FREQ] || !freq_valid;
	end

	generate
		for (genvar d = 0; d < trig_pkg::NUM_DET; d++) begin : g_det
			det_timer u_timer (
				.clock        (clock),
				.rst          (rst),
				.tick         (tick),
				.clear        (clear[d]),
				.cond         (cond[d]),
				.pickup_time  (pickup_time[d]),
				.dropout_time (dropout_time[d]),
				.active       (active[d])
			);
		end
	endgenerate

	// ----------------------------------------
	// Outputs
	// ----------------------------------------
	always_ff @(posedge clock) begin
		if (rst) begin
			trigger          <= 4'h0;
			recorder_trigger <= 1'b0;
			event_pickup     <= 4'h0;
			event_dropout    <= 4'h0;
		end else begin
			trigger          <= active;
			recorder_trigger <= |active;
			event_pickup     <= active & ~trigger & events;
			event_dropout    <= ~active & trigger & events;
		end
	end

	// ----------------------------------------
	// Checks
	// ----------------------------------------
	sequence bus_req;
		(avs_read || avs_write) && avs_waitrequest;
	endsequence

	sequence bus_done;
		!avs_waitrequest ##1 avs_waitrequest;
	endsequence

	chk_bus_answer: assert property (
		@(posedge clock) disable iff (rst) bus_req |=> bus_done)
		else $error("bus request not answered in one cycle");

	chk_disabled_quiet: assert property (
		@(posedge clock) disable iff (rst) (enable == 4'h0) [*2] |=> trigger == 4'h0)
		else $error("disabled detector triggered");

	chk_or_combine: assert property (
		@(posedge clock) disable iff (rst) recorder_trigger == (|trigger))
		else $error("recorder trigger differs from OR of detectors");

	chk_block_inhibit: assert property (
		@(posedge clock) disable iff (rst) block[trig_pkg::DET_FREQ] |-> ##2 !trigger[0])
		else $error("blocked frequency detector triggered");

	chk_freq_dropout: assert property (
		@(posedge clock) disable iff (rst) !freq_valid |-> ##2 !trigger[0])
		else $error("frequency trigger held without valid frequency");

	chk_event_log: assert property (
		@(posedge clock) disable iff (rst)
		$rose(trigger[1]) |-> event_pickup[1] == $past(events[1]))
		else $error("voltage pickup logging wrong");

	chk_dead_suppress: assert property (
		@(posedge clock) disable iff (rst)
		(refresh && phase_volt[0] < trig_pkg::DEAD_VOLT) |=> !volt_live[0])
		else $error("dead voltage channel left live");

	chk_refresh_pulse: assert property (
		@(posedge clock) disable iff (rst) refresh |=> !refresh)
		else $error("refresh longer than one cycle");
endmodule

// ==== sim/meas_src.sv ====
`timescale 1ns/1ns
module meas_src (
	input  wire logic                  clock,
	output logic      [15:0]           frequency,
	output logic                       freq_valid,
	output logic      [2:0][15:0]      phase_volt,
	output logic      [2:0][15:0]      phase_curr,
	output logic      [2:0][2:0][15:0] phase_power,
	output logic      [2:0][15:0]      total_power
);
	// ----
	// Nominal system, inside every default band
	// ----
	initial begin
		frequency   = 16'h1770;
		freq_valid  = 1'b1;
		phase_volt  = {3{16'h03e8}};
		phase_curr  = {3{16'h03e8}};
		phase_power = {9{16'h03e8}};
		total_power = {3{16'h0bb8}};
	end

	// ----
	// Updates land just after an edge, so no refresh sees half a change
	// ----
	task automatic put_freq(input logic [15:0] f, input logic ok);
		@(posedge clock);
		frequency  <= f;
		freq_valid <= ok;
	endtask

	task automatic put_volt(input int i, input logic [15:0] v);
		@(posedge clock);
		phase_volt[i] <= v;
	endtask

	task automatic put_curr(input int i, input logic [15:0] v);
		@(posedge clock);
		phase_curr[i] <= v;
	endtask

	task automatic put_pow(input int t, input int i, input logic [15:0] v);
		@(posedge clock);
		phase_power[t][i] <= v;
	endtask

	task automatic put_total(input int t, input logic [15:0] v);
		@(posedge clock);
		total_power[t] <= v;
	endtask
endmodule

// ==== sim/tb_top.sv ====
`timescale 1ns/1ns
`define CHK(got, exp) begin checks++; if ((got) !== (exp)) begin err_count++; \
	$display("Error at %0t ns: got %h expected %h", $time, (got), (exp)); end end
module tb_top;
	// ----
	// Short counts keep the run small
	// ----
	localparam int TICK   = 4;
	localparam int REFR   = 8;
	localparam int SETTLE = 3 * REFR + 6;

	logic                  clock = 1'b0;
	logic                  rst = 1'b1;
	logic [7:0]            avs_address = 8'h00;
	logic                  avs_read = 1'b0;
	logic                  avs_write = 1'b0;
	logic [31:0]           avs_writedata = 32'h0;
	logic [31:0]           avs_readdata;
	logic                  avs_waitrequest;
	logic [15:0]           frequency;
	logic                  freq_valid;
	logic [2:0][15:0]      phase_volt;
	logic [2:0][15:0]      phase_curr;
	logic [2:0][2:0][15:0] phase_power;
	logic [2:0][15:0]      total_power;
	logic [3:0]            block = 4'h0;
	logic [3:0]            trigger;
	logic                  recorder_trigger;
	logic [3:0]            event_pickup;
	logic [3:0]            event_dropout;
	int                    err_count = 0;
	int                    checks = 0;
	int                    pick_cnt [4] = '{0, 0, 0, 0};
	int                    drop_cnt [4] = '{0, 0, 0, 0};
	int                    n;

	always #50 clock = ~clock;

	trig_top #(.TICK_CYCLES(TICK), .REFRESH_CYCLES(REFR)) dut (
		.clock(clock), .rst(rst), .avs_address(avs_address), .avs_read(avs_read),
		.avs_write(avs_write), .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
		.avs_waitrequest(avs_waitrequest), .frequency(frequency), .freq_valid(freq_valid),
		.phase_volt(phase_volt), .phase_curr(phase_curr), .phase_power(phase_power),
		.total_power(total_power), .block(block), .trigger(trigger),
		.recorder_trigger(recorder_trigger), .event_pickup(event_pickup),
		.event_dropout(event_dropout)
	);

	meas_src src (
		.clock(clock), .frequency(frequency), .freq_valid(freq_valid),
		.phase_volt(phase_volt), .phase_curr(phase_curr), .phase_power(phase_power),
		.total_power(total_power)
	);

	always @(posedge clock) begin
		for (int i = 0; i < 4; i++) begin
			if (event_pickup[i] === 1'b1) pick_cnt[i]++;
			if (event_dropout[i] === 1'b1) drop_cnt[i]++;
		end
	end

	// ----
	// Closing report
	// ----
	task automatic wrap_up();
		$display("Comparisons %0d, mismatches %0d", checks, err_count);
		if (err_count == 0 && checks > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask

	initial begin
		repeat (20000) @(posedge clock);
		err_count++;
		wrap_up();
	end

	// ----
	// Bus cycles: hold until waitrequest is seen low
	// ----
	task automatic bus(input logic wr, input logic [7:0] addr, input logic [31:0] wd,
		output logic [31:0] rd);
		int k;
		k = 0;
		@(posedge clock);
		avs_address   <= addr;
		avs_write     <= wr;
		avs_read      <= !wr;
		avs_writedata <= wd;
		do begin
			@(posedge clock);
			k++;
		end while (avs_waitrequest !== 1'b0 && k < 20);
		rd = avs_readdata;
		avs_write <= 1'b0;
		avs_read  <= 1'b0;
		if (k >= 20) begin
			err_count++;
			wrap_up();
		end
	endtask

	task automatic wr(input logic [7:0] addr, input logic [31:0] wd);
		logic [31:0] d;
		bus(1'b1, addr, wd, d);
	endtask

	task automatic chk_rd(input logic [7:0] addr, input logic [31:0] exp);
		logic [31:0] d;
		bus(1'b0, addr, 32'h0, d);
		`CHK(d, exp)
	endtask

	// ----
	// Detector helpers
	// ----
	task automatic expect_trig(input int d, input logic v);
		repeat (SETTLE) @(posedge clock);
		`CHK(trigger[d], v)
		`CHK(recorder_trigger, |trigger)
	endtask

	task automatic wait_trig(input int d, input logic v, output int cnt);
		cnt = 0;
		while (trigger[d] !== v && cnt < 200) begin
			@(posedge clock);
			cnt++;
		end
		if (cnt >= 200) begin
			err_count++;
			wrap_up();
		end
	endtask

	task automatic end_test(input string name);
		$display("Test %s done, mismatches so far %0d", name, err_count);
	endtask

	initial begin
		repeat (8) @(posedge clock);
		rst <= 1'b0;
		chk_rd(trig_pkg::ADDR_CONTROL, 32'h0);
		for (int i = 0; i < 8; i++) begin
			chk_rd(trig_pkg::ADDR_THRESH + 8'(4 * i), 32'(trig_pkg::TH_RESET[i]));
		end
		for (int d = 0; d < 4; d++) begin
			chk_rd(trig_pkg::ADDR_PICKUP + 8'(4 * d), 32'h0000000a);
			chk_rd(trig_pkg::ADDR_DROPOUT + 8'(4 * d), 32'h00000064);
		end
		chk_rd(8'h80, 32'h0);
		end_test("reset values");

		wr(trig_pkg::ADDR_THRESH, 32'h0);
		chk_rd(trig_pkg::ADDR_THRESH, 32'(trig_pkg::TH_MIN[0]));
		wr(trig_pkg::ADDR_THRESH + 8'h0c, 32'h0000ffff);
		chk_rd(trig_pkg::ADDR_THRESH + 8'h0c, 32'(trig_pkg::TH_MAX[3]));
		wr(trig_pkg::ADDR_PICKUP, 32'h0000ffff);
		chk_rd(trig_pkg::ADDR_PICKUP, 32'(trig_pkg::TIME_MAX));
		wr(trig_pkg::ADDR_THRESH, 32'(trig_pkg::TH_RESET[0]));
		wr(trig_pkg::ADDR_THRESH + 8'h0c, 32'(trig_pkg::TH_RESET[3]));
		for (int d = 0; d < 4; d++) begin
			wr(trig_pkg::ADDR_PICKUP + 8'(4 * d), 32'h0);
			wr(trig_pkg::ADDR_DROPOUT + 8'(4 * d), 32'h0);
		end
		end_test("clamping");

		src.put_freq(16'h12c0, 1'b1);
		expect_trig(0, 1'b0);
		wr(trig_pkg::ADDR_CONTROL, 32'h11);
		expect_trig(0, 1'b1);
		`CHK(pick_cnt[0], 1)
		src.put_freq(16'h1326, 1'b1);
		expect_trig(0, 1'b1);
		src.put_freq(16'h1328, 1'b1);
		expect_trig(0, 1'b0);
		`CHK(drop_cnt[0], 1)
		src.put_freq(16'h17d5, 1'b1);
		expect_trig(0, 1'b1);
		src.put_freq(16'h17d3, 1'b1);
		expect_trig(0, 1'b1);
		src.put_freq(16'h17d0, 1'b1);
		expect_trig(0, 1'b0);
		src.put_freq(16'h12c0, 1'b0);
		expect_trig(0, 1'b0);
		src.put_freq(16'h12c0, 1'b1);
		expect_trig(0, 1'b1);
		wr(trig_pkg::ADDR_CONTROL, 32'h10);
		expect_trig(0, 1'b0);
		wr(trig_pkg::ADDR_CONTROL, 32'h11);
		expect_trig(0, 1'b1);
		block <= 4'h1;
		expect_trig(0, 1'b0);
		block <= 4'h0;
		src.put_freq(16'h1770, 1'b1);
		expect_trig(0, 1'b0);
		end_test("frequency");

		wr(trig_pkg::ADDR_CONTROL, 32'h1f);
		for (int i = 0; i < 3; i++) begin
			src.put_volt(i, 16'h0316);
			expect_trig(1, 1'b1);
			src.put_volt(i, 16'h04b1);
			expect_trig(1, 1'b1);
			src.put_volt(i, 16'h03e8);
			expect_trig(1, 1'b0);
			src.put_volt(i, 16'h0032);
			expect_trig(1, 1'b0);
			src.put_volt(i, 16'h03e8);
		end
		`CHK(pick_cnt[1], 0)
		end_test("voltage");

		for (int i = 0; i < 3; i++) begin
			src.put_curr(i, 16'h0709);
			expect_trig(2, 1'b1);
			src.put_curr(i, 16'h06e0);
			expect_trig(2, 1'b1);
			src.put_curr(i, 16'h06cc);
			expect_trig(2, 1'b0);
			src.put_curr(i, 16'h03e8);
		end
		end_test("current");

		for (int t = 0; t < 3; t++) begin
			for (int i = 0; i < 3; i++) begin
				src.put_pow(t, i, 16'h04e3);
				expect_trig(3, 1'b1);
				src.put_pow(t, i, 16'h03e8);
			end
			src.put_total(t, 16'h0e74);
			expect_trig(3, 1'b0);
			src.put_total(t, 16'h0ea7);
			expect_trig(3, 1'b1);
			src.put_total(t, 16'h0bb8);
			expect_trig(3, 1'b0);
		end
		end_test("power");

		wr(trig_pkg::ADDR_PICKUP + 8'h08, 32'h5);
		wr(trig_pkg::ADDR_DROPOUT + 8'h08, 32'h5);
		src.put_curr(0, 16'h0709);
		wait_trig(2, 1'b1, n);
		`CHK((n >= 4 * TICK) && (n <= 48), 1'b1)
		src.put_curr(0, 16'h03e8);
		wait_trig(2, 1'b0, n);
		`CHK((n >= 4 * TICK) && (n <= 48), 1'b1)
		end_test("timers");
		wrap_up();
	end
endmodule
